// [verilog/write_handler_defines.svh]
`ifndef WRITE_HANDLER_DEFINES_SVH
`define WRITE_HANDLER_DEFINES_SVH

// ------------------------------------------------------------
// function codes handled here
// ------------------------------------------------------------
`define FC_WRITE_COIL 8'h05
`define FC_WRITE_WORD 8'h06
`define FC_WRITE_COILS 8'h0F
`define FC_WRITE_WORDS 8'h10

// ------------------------------------------------------------
// address map of the output image
// ------------------------------------------------------------
`define COIL_BASE_ADDR 16'h0000
`define WORD_BASE_ADDR 16'h0800

// ------------------------------------------------------------
// single output data values
// ------------------------------------------------------------
`define COIL_ON_VALUE 8'hFF
`define COIL_OFF_VALUE 8'h00

// ------------------------------------------------------------
// byte positions inside a query (slave address is position 0)
// ------------------------------------------------------------
`define POS_SLAVE 9'h000
`define POS_FUNC 9'h001
`define POS_ADDR_HI 9'h002
`define POS_ADDR_LO 9'h003
`define POS_VAL_HI 9'h004
`define POS_VAL_LO 9'h005
`define POS_BYTE_CNT 9'h006
`define POS_DATA0 9'h007
`define POS_MAX 9'h1FF

// ------------------------------------------------------------
// reset values and buffer sizing
// ------------------------------------------------------------
`define IMAGE_RESET_VALUE 1'b0
`define WORD_RESET_VALUE 16'h0000
`define FIFO_DEPTH_DEFAULT 32
`define FIFO_WIDTH_DEFAULT 8

`endif

// [verilog/write_handler_pkg.sv]
package write_handler_pkg;
   // echo engine states
   typedef enum logic [1:0] {ST_RECV, ST_ECHO, ST_FLUSH} echo_state_t;
   // one analogue output word
   typedef logic [15:0] out_word_t;
endpackage

// [verilog/fifo_if.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// carrier between the handler and its byte buffer
// ------------------------------------------------------------
interface fifo_if #(parameter int WIDTH = 8);
   logic in_valid; // producer offers a word
   logic in_ready; // buffer has room
   logic [WIDTH-1:0] in_data; // word to store
   logic out_valid; // head word present
   logic out_ready; // consumer takes head
   logic [WIDTH-1:0] out_data; // head word, from a register
   logic empty; // nothing stored, nothing at head
   modport fifo_side (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data, empty);
   modport user_side (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data, empty);
endinterface

// [verilog/byte_fifo.sv]
`timescale 1ns/1ps
`include "write_handler_defines.svh"
// ------------------------------------------------------------
// buffer with registered head word
// ------------------------------------------------------------
module byte_fifo #(
   parameter int WIDTH = `FIFO_WIDTH_DEFAULT,
   parameter int DEPTH = `FIFO_DEPTH_DEFAULT
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   fifo_if.fifo_side bus
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH]; // storage array
   logic [AW-1:0] wr_ptr_ff; // next write slot
   logic [AW-1:0] rd_ptr_ff; // next read slot
   logic [AW:0] count_ff; // words in the array
   logic out_valid_ff; // head register holds a word
   logic [WIDTH-1:0] out_data_ff; // head register
   logic push; // word enters array
   logic load; // array word moves to head

   assign push = bus.in_valid && bus.in_ready;
   assign load = (count_ff != '0) && (!out_valid_ff || bus.out_ready);
   assign bus.in_ready = (count_ff != (AW+1)'(DEPTH));
   assign bus.out_valid = out_valid_ff;
   assign bus.out_data = out_data_ff;
   assign bus.empty = (count_ff == '0) && !out_valid_ff;

   // array write, no reset needed on data
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= bus.in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (load) begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
         end
         count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(load);
      end
   end

   // head register
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         out_valid_ff <= 1'b0;
         out_data_ff <= '0;
      end else if (load) begin
         out_valid_ff <= 1'b1;
         out_data_ff <= mem_ff[rd_ptr_ff];
      end else if (bus.out_ready) begin
         out_valid_ff <= 1'b0;
      end
   end
endmodule // byte_fifo

// [verilog/output_write_handler.sv]
`timescale 1ns/1ps
`include "write_handler_defines.svh"
// Functional notes
// - code 5 writes one digital output
// - digital output bit addresses start at zero
// - output state taken from data high byte
// - successful write echoes the received query (only the six header bytes for code 16)
// - code 6 writes one sixteen-bit word
// - output words start at word address 0800
// - single word address is a word index
// - code 15 writes several consecutive digital outputs
// - multiple coil start address is a bit index
// - data bytes carry bits in ascending order
// - code 16 writes several consecutive output words
// - words high byte first, placed consecutively
// - ascii framing colon, crlf, hex pairs (removed upstream, bytes arrive here de-framed)
module output_write_handler #(
   parameter int NUM_COILS = 32,
   parameter int NUM_WORDS = 8,
   parameter int FIFO_DEPTH = `FIFO_DEPTH_DEFAULT
) (
   input wire logic CORE_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic RX_VALID_IN,
   input wire logic [7:0] RX_DATA_IN,
   input wire logic RX_SOF_IN,
   input wire logic RX_EOF_IN,
   input wire logic RX_CHECK_OK_IN,
   output logic RX_READY_OUT,
   output logic TX_VALID_OUT,
   output logic [7:0] TX_DATA_OUT,
   output logic TX_LAST_OUT,
   input wire logic TX_READY_IN,
   output logic [NUM_COILS-1:0] COIL_IMAGE_OUT,
   output logic [NUM_WORDS*16-1:0] WORD_IMAGE_OUT,
   output logic WRITE_DONE_OUT,
   output logic FRAME_DROP_OUT
);
   localparam int CIDX_W = (NUM_COILS > 1) ? $clog2(NUM_COILS) : 1;
   localparam int WIDX_W = (NUM_WORDS > 1) ? $clog2(NUM_WORDS) : 1;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   write_handler_pkg::echo_state_t state_ff; // echo engine state
   write_handler_pkg::echo_state_t nxt_state; // its next value
   logic rx_ready_ff; // byte intake open
   logic [8:0] idx_ff; // position of next byte in frame
   logic [8:0] cur_idx; // position of the byte now offered
   logic [7:0] fc_ff; // function code of the frame
   logic [7:0] addr_hi_ff; // start address high
   logic [15:0] start_ff; // start address
   logic [7:0] hi_ff; // data or length high
   logic [7:0] lo_ff; // data or length low
   logic [7:0] bcnt_ff; // byte count field
   logic [7:0] first_byte_ff; // first stored byte, for checking
   logic [5:0] stored_ff; // bytes buffered this frame
   logic [5:0] echo_left_ff; // bytes still to send
   logic commit_ff; // frame passed, copy stage to image
   logic tx_valid_ff; // output byte register full
   logic [7:0] tx_data_ff; // output byte
   logic tx_last_ff; // output byte ends the reply
   logic drop_ff; // frame dropped pulse
   logic [NUM_COILS-1:0] coil_stage_ff; // coil image being built
   logic [NUM_COILS-1:0] coil_image_ff; // live coil image
   write_handler_pkg::out_word_t word_stage_ff [NUM_WORDS]; // words being built
   write_handler_pkg::out_word_t word_image_ff [NUM_WORDS]; // live words
   logic accept; // byte taken this cycle
   logic store; // byte goes into the echo buffer
   logic pop; // buffer head moves to tx register
   logic frame_good; // all field checks pass at end of frame
   logic [15:0] cnt; // length field
   logic [15:0] rel; // start relative to word base
   logic [16:0] bits_up; // bit count plus seven
   logic [16:0] coil_end; // start plus count
   logic [16:0] word_end; // relative start plus count
   logic [8:0] last_idx; // position of last data byte
   logic [8:0] data_k; // data byte number

   fifo_if #(.WIDTH(8)) fifo_bus ();

   // ------------------------------------------------------------
   // echo buffer
   // ------------------------------------------------------------
   byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_echo_fifo (
      .clk_in(CORE_CLK_IN),
      .rst_n_in(RESETN_IN),
      .bus(fifo_bus)
   );

   // bytes arrive already de-framed (colon, crlf, hex pairs removed upstream)
   assign accept = RX_VALID_IN && rx_ready_ff;
   assign cur_idx = RX_SOF_IN ? `POS_SLAVE : idx_ff;
   assign cnt = {hi_ff, lo_ff};
   assign rel = start_ff - `WORD_BASE_ADDR;
   assign data_k = cur_idx - `POS_DATA0;
   // code 16 echo only holds the header
   assign store = (fc_ff == `FC_WRITE_WORDS && cur_idx > `POS_VAL_LO) ? 1'b0 : (cur_idx < 9'(FIFO_DEPTH));
   assign fifo_bus.in_valid = accept && store;
   assign fifo_bus.in_data = RX_DATA_IN;
   assign pop = (state_ff == write_handler_pkg::ST_ECHO) && fifo_bus.out_valid && (!tx_valid_ff || TX_READY_IN);
   assign fifo_bus.out_ready = (state_ff == write_handler_pkg::ST_FLUSH) || pop;

   // ------------------------------------------------------------
   // field capture
   // ------------------------------------------------------------
   // byte position counter, restarts after each frame end
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         idx_ff <= `POS_SLAVE;
      end else if (accept) begin
         if (RX_EOF_IN) begin
            idx_ff <= `POS_SLAVE;
         end else if (cur_idx != `POS_MAX) begin
            idx_ff <= cur_idx + 9'h001;
         end
      end
   end

   // header fields of the query
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         fc_ff <= 8'h00;
         addr_hi_ff <= 8'h00;
         start_ff <= 16'h0000;
         hi_ff <= 8'h00;
         lo_ff <= 8'h00;
         bcnt_ff <= 8'h00;
         first_byte_ff <= 8'h00;
      end else if (accept) begin
         unique case (cur_idx)
            `POS_SLAVE: first_byte_ff <= RX_DATA_IN;
            `POS_FUNC: fc_ff <= RX_DATA_IN;
            `POS_ADDR_HI: addr_hi_ff <= RX_DATA_IN;
            `POS_ADDR_LO: start_ff <= {addr_hi_ff, RX_DATA_IN};
            `POS_VAL_HI: hi_ff <= RX_DATA_IN; // state or length high
            `POS_VAL_LO: lo_ff <= RX_DATA_IN;
            `POS_BYTE_CNT: bcnt_ff <= RX_DATA_IN;
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // frame checks at the end byte
   // ------------------------------------------------------------
   always_comb begin
      bits_up = {1'b0, cnt} + 17'h0_0007;
      coil_end = {1'b0, start_ff} + {1'b0, cnt};
      word_end = {1'b0, rel} + {1'b0, cnt};
      last_idx = `POS_BYTE_CNT + {1'b0, bcnt_ff};
      frame_good = 1'b0;
      unique case (fc_ff)
         `FC_WRITE_COIL: begin
            frame_good = (start_ff < 16'(NUM_COILS)) && (cur_idx == `POS_VAL_LO)
               && (hi_ff == `COIL_ON_VALUE || hi_ff == `COIL_OFF_VALUE);
         end
         `FC_WRITE_WORD: begin
            frame_good = (start_ff >= `WORD_BASE_ADDR) && (rel < 16'(NUM_WORDS))
               && (cur_idx == `POS_VAL_LO);
         end
         `FC_WRITE_COILS: begin
            frame_good = (cnt != 16'h0000) && (coil_end <= 17'(NUM_COILS))
               && ({6'h00, bcnt_ff} == bits_up[16:3]) && (cur_idx == last_idx);
         end
         `FC_WRITE_WORDS: begin
            frame_good = (cnt != 16'h0000) && (start_ff >= `WORD_BASE_ADDR) && (word_end <= 17'(NUM_WORDS))
               && ({8'h00, bcnt_ff} == {cnt[14:0], 1'b0}) && !cnt[15] && (cur_idx == last_idx);
         end
         default: frame_good = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // staging images, copied to live image only on a good frame
   // ------------------------------------------------------------
   for (genvar gi = 0; gi < NUM_COILS; gi++) begin : g_coil
      logic [15:0] off; // distance from start bit
      assign off = 16'(gi) - start_ff;
      // one staged coil
      always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
         if (!RESETN_IN) begin
            coil_stage_ff[gi] <= `IMAGE_RESET_VALUE;
         end else if (accept && cur_idx == `POS_SLAVE) begin
            coil_stage_ff[gi] <= coil_image_ff[gi]; // fresh copy per frame
         end else if (accept && fc_ff == `FC_WRITE_COIL && cur_idx == `POS_VAL_LO && start_ff == 16'(gi)) begin
            coil_stage_ff[gi] <= (hi_ff == `COIL_ON_VALUE);
         end else if (accept && fc_ff == `FC_WRITE_COILS && cur_idx >= `POS_DATA0 && off < cnt
            && off[15:3] == {4'h0, data_k}) begin
            coil_stage_ff[gi] <= RX_DATA_IN[off[2:0]]; // bit index, bytes in order
         end
      end
   end

   for (genvar gw = 0; gw < NUM_WORDS; gw++) begin : g_word
      logic [15:0] woff; // distance from start word
      assign woff = 16'(gw) - rel;
      // one staged word
      always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
         if (!RESETN_IN) begin
            word_stage_ff[gw] <= `WORD_RESET_VALUE;
         end else if (accept && cur_idx == `POS_SLAVE) begin
            word_stage_ff[gw] <= word_image_ff[gw];
         end else if (accept && fc_ff == `FC_WRITE_WORD && cur_idx == `POS_VAL_LO && rel == 16'(gw)) begin
            word_stage_ff[gw] <= {hi_ff, RX_DATA_IN}; // word index from 0800
         end else if (accept && fc_ff == `FC_WRITE_WORDS && cur_idx >= `POS_DATA0 && woff < cnt
            && woff[15:0] == {8'h00, data_k[8:1]}) begin
            if (!data_k[0]) begin
               word_stage_ff[gw][15:8] <= RX_DATA_IN; // high byte first
            end else begin
               word_stage_ff[gw][7:0] <= RX_DATA_IN;
            end
         end
      end
      assign WORD_IMAGE_OUT[gw*16 +: 16] = word_image_ff[gw];
   end

   // live images, only from a checked frame
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         coil_image_ff <= '0;
         for (int i = 0; i < NUM_WORDS; i++) begin
            word_image_ff[i] <= `WORD_RESET_VALUE;
         end
      end else if (commit_ff) begin
         coil_image_ff <= coil_stage_ff;
         word_image_ff <= word_stage_ff;
      end
   end
   assign COIL_IMAGE_OUT = coil_image_ff;

   // ------------------------------------------------------------
   // echo engine
   // ------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         write_handler_pkg::ST_RECV: begin
            if (accept && RX_EOF_IN) begin
               // bad check or bad fields: no echo
               nxt_state = (RX_CHECK_OK_IN && frame_good) ? write_handler_pkg::ST_ECHO
                  : write_handler_pkg::ST_FLUSH;
            end
         end
         write_handler_pkg::ST_ECHO: begin
            if (echo_left_ff == 6'h00 && tx_valid_ff && tx_last_ff && TX_READY_IN) begin
               nxt_state = write_handler_pkg::ST_RECV;
            end
         end
         write_handler_pkg::ST_FLUSH: begin
            if (fifo_bus.empty) begin
               nxt_state = write_handler_pkg::ST_RECV;
            end
         end
         default: nxt_state = write_handler_pkg::ST_RECV;
      endcase
   end

   // state, intake gate and commit pulse
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         state_ff <= write_handler_pkg::ST_RECV;
         rx_ready_ff <= 1'b0;
         commit_ff <= 1'b0;
         drop_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         rx_ready_ff <= (nxt_state == write_handler_pkg::ST_RECV) && fifo_bus.in_ready;
         commit_ff <= accept && RX_EOF_IN && RX_CHECK_OK_IN && frame_good;
         drop_ff <= accept && RX_EOF_IN && !(RX_CHECK_OK_IN && frame_good);
      end
   end

   // byte counts for the reply
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         stored_ff <= 6'h00;
         echo_left_ff <= 6'h00;
      end else begin
         if (accept) begin
            stored_ff <= ((cur_idx == `POS_SLAVE) ? 6'h00 : stored_ff) + 6'(fifo_bus.in_valid);
         end
         if (accept && RX_EOF_IN) begin
            echo_left_ff <= stored_ff + 6'(fifo_bus.in_valid); // reply repeats the buffered query bytes (header only for code 16)
         end else if (pop) begin
            echo_left_ff <= echo_left_ff - 6'h01;
         end
      end
   end

   // output byte register
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         tx_valid_ff <= 1'b0;
         tx_data_ff <= 8'h00;
         tx_last_ff <= 1'b0;
      end else if (pop) begin
         tx_valid_ff <= 1'b1;
         tx_data_ff <= fifo_bus.out_data;
         tx_last_ff <= (echo_left_ff == 6'h01);
      end else if (TX_READY_IN) begin
         tx_valid_ff <= 1'b0;
         tx_last_ff <= 1'b0;
      end
   end

   assign RX_READY_OUT = rx_ready_ff;
   assign TX_VALID_OUT = tx_valid_ff;
   assign TX_DATA_OUT = tx_data_ff;
   assign TX_LAST_OUT = tx_last_ff;
   assign WRITE_DONE_OUT = commit_ff;
   assign FRAME_DROP_OUT = drop_ff;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sequence s_good_end;
      accept && RX_EOF_IN && RX_CHECK_OK_IN && frame_good;
   endsequence
   sequence s_bad_end;
      accept && RX_EOF_IN && !(RX_CHECK_OK_IN && frame_good);
   endsequence
   sequence s_first_echo;
      TX_VALID_OUT && TX_DATA_OUT == first_byte_ff;
   endsequence

   AST_COIL_SINGLE: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      (s_good_end and fc_ff == `FC_WRITE_COIL) |=> ##1
      coil_image_ff[$past(start_ff[CIDX_W-1:0], 2)] == $past(hi_ff == `COIL_ON_VALUE, 2))
      else $error("single coil not written from high byte");
   AST_COIL_RANGE: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      (accept && RX_EOF_IN && fc_ff == `FC_WRITE_COIL && start_ff >= 16'(NUM_COILS)) |=> !commit_ff)
      else $error("out of range coil accepted");
   AST_WORD_SINGLE: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      (s_good_end and fc_ff == `FC_WRITE_WORD) |=> ##1
      word_image_ff[$past(rel[WIDX_W-1:0], 2)] == $past({hi_ff, RX_DATA_IN}, 2))
      else $error("single word not written at word index");
   AST_WORD_BASE: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      (accept && RX_EOF_IN && fc_ff == `FC_WRITE_WORD && start_ff < `WORD_BASE_ADDR) |=> !commit_ff)
      else $error("word below base accepted");
   AST_COILS_FIRST: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      (accept && fc_ff == `FC_WRITE_COILS && cur_idx == `POS_DATA0 && cnt != 16'h0000
      && start_ff < 16'(NUM_COILS)) |=> coil_stage_ff[$past(start_ff[CIDX_W-1:0])] == $past(RX_DATA_IN[0]))
      else $error("first coil not from bit zero of first byte");
   AST_WORDS_HIGH: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      (accept && fc_ff == `FC_WRITE_WORDS && cur_idx == `POS_DATA0 && cnt != 16'h0000
      && start_ff >= `WORD_BASE_ADDR && rel < 16'(NUM_WORDS))
      |=> word_stage_ff[$past(rel[WIDX_W-1:0])][15:8] == $past(RX_DATA_IN))
      else $error("first word byte not placed high");
   AST_ECHO_START: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      s_good_end |=> ##1 s_first_echo)
      else $error("echo does not start with the query");
   AST_NO_ECHO_BAD: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      s_bad_end |=> (!TX_VALID_OUT && !commit_ff) [*8])
      else $error("reply or write after a bad frame");
   AST_IMAGE_HOLD: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      !$stable(coil_image_ff) |-> $past(commit_ff))
      else $error("coil image changed without a checked frame");
   AST_FLUSH_ENDS: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
      s_bad_end |-> ##[1:40] state_ff == write_handler_pkg::ST_RECV)
      else $error("dropped frame not flushed in time");
endmodule // output_write_handler

// [tb/query_master_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// master side: sends de-framed queries, collects the reply
// ------------------------------------------------------------
module query_master_model (
   input wire logic clk_in,
   input wire logic rx_ready_in,
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_data_in,
   input wire logic tx_last_in,
   output logic rx_valid_out,
   output logic [7:0] rx_data_out,
   output logic rx_sof_out,
   output logic rx_eof_out,
   output logic rx_ok_out,
   output logic tx_ready_out
);
   logic [7:0] got_q[$]; // reply bytes taken
   logic slow = 1'b0; // stall every other cycle
   int last_at = 0; // reply position that carried the last marker
   logic nxt_ready;
   initial begin
      rx_valid_out = 1'b0;
      rx_data_out = 8'h00;
      rx_sof_out = 1'b0;
      rx_eof_out = 1'b0;
      rx_ok_out = 1'b0;
      tx_ready_out = 1'b1;
   end
   // reply byte recorded when the next edge takes it
   always @(negedge clk_in) begin
      nxt_ready = slow ? ~tx_ready_out : 1'b1;
      if (tx_valid_in === 1'b1 && nxt_ready) begin
         got_q.push_back(tx_data_in);
         if (tx_last_in === 1'b1) last_at = got_q.size();
      end
      tx_ready_out <= nxt_ready;
   end
   // one query, each byte held until taken
   task send_query(input logic [7:0] q[$], input logic ok);
      for (int i = 0; i < q.size(); i++) begin
         @(negedge clk_in);
         rx_valid_out = 1'b1;
         rx_data_out = q[i];
         rx_sof_out = (i == 0);
         rx_eof_out = (i == q.size() - 1);
         rx_ok_out = ok;
         while (rx_ready_in !== 1'b1) @(negedge clk_in);
      end
      @(negedge clk_in);
      rx_valid_out = 1'b0;
      rx_data_out = ~rx_data_out; // released line: no stale value
      rx_eof_out = 1'b0;
   endtask
endmodule // query_master_model

// [tb/output_write_handler_tb.sv]
`timescale 1ns/1ps
`include "write_handler_defines.svh"
module output_write_handler_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic rx_valid, rx_sof, rx_eof, rx_ok, rx_ready, tx_valid, tx_last, tx_ready, done, drop;
   logic [7:0] rx_data, tx_data;
   logic [31:0] coils, exp_coils = 32'h0000_0000;
   logic [127:0] words, exp_words = 0;
   int errors = 0, comparisons = 0, n_done = 0, n_drop = 0;
   always #12.5 clk = ~clk;
   always @(negedge clk) begin
      if (done === 1'b1) n_done++;
      if (drop === 1'b1) n_drop++;
   end
   query_master_model i_master (.clk_in(clk), .rx_ready_in(rx_ready), .tx_valid_in(tx_valid),
      .tx_data_in(tx_data), .tx_last_in(tx_last), .rx_valid_out(rx_valid), .rx_data_out(rx_data), .rx_sof_out(rx_sof),
      .rx_eof_out(rx_eof), .rx_ok_out(rx_ok), .tx_ready_out(tx_ready));
   output_write_handler i_dut (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .RX_VALID_IN(rx_valid),
      .RX_DATA_IN(rx_data), .RX_SOF_IN(rx_sof), .RX_EOF_IN(rx_eof), .RX_CHECK_OK_IN(rx_ok),
      .RX_READY_OUT(rx_ready), .TX_VALID_OUT(tx_valid), .TX_DATA_OUT(tx_data), .TX_LAST_OUT(tx_last),
      .TX_READY_IN(tx_ready), .COIL_IMAGE_OUT(coils), .WORD_IMAGE_OUT(words),
      .WRITE_DONE_OUT(done), .FRAME_DROP_OUT(drop));
   task check_val(input string name, input logic [127:0] exp, input logic [127:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   // send, wait for intake to reopen, judge outcome and echo
   task run(input logic [7:0] q[$], input logic ok, input int nrep, input int dn);
      int d0, p0;
      d0 = n_done;
      p0 = n_drop;
      i_master.got_q.delete();
      i_master.last_at = 0;
      i_master.send_query(q, ok);
      repeat (3) @(negedge clk);
      for (int i = 0; i < 300 && rx_ready !== 1'b1; i++) @(negedge clk);
      check_val("intake reopen", 1, rx_ready);
      check_val("done count", dn, n_done - d0);
      check_val("drop count", 1 - dn, n_drop - p0);
      check_val("reply length", nrep, i_master.got_q.size());
      check_val("last marker", nrep, i_master.last_at);
      for (int i = 0; i < nrep && i < i_master.got_q.size(); i++) begin
         check_val("reply byte", q[i], i_master.got_q[i]);
      end
   endtask
   task test_single;
      exp_coils[2] = 1'b1;
      run('{8'h0B, `FC_WRITE_COIL, 8'h00, 8'h02, `COIL_ON_VALUE, 8'h00}, 1'b1, 6, 1);
      check_val("coil image", exp_coils, coils);
      exp_coils[2] = 1'b0;
      run('{8'h0B, `FC_WRITE_COIL, 8'h00, 8'h02, `COIL_OFF_VALUE, 8'h00}, 1'b1, 6, 1);
      check_val("coil image", exp_coils, coils);
      i_master.slow = 1'b1;
      exp_words[3*16 +: 16] = 16'h3FFF;
      run('{8'h0B, `FC_WRITE_WORD, 8'h08, 8'h03, 8'h3F, 8'hFF}, 1'b1, 6, 1);
      check_val("word image", exp_words, words);
      $display("test single done");
   endtask
   task test_multi;
      exp_coils[12:3] = 10'h2A5;
      run('{8'h0B, `FC_WRITE_COILS, 8'h00, 8'h03, 8'h00, 8'h0A, 8'h02, 8'hA5, 8'h02}, 1'b1, 9, 1);
      check_val("coil image", exp_coils, coils);
      i_master.slow = 1'b0;
      exp_words[15:0] = 16'h7FFF;
      exp_words[31:16] = 16'h3FFF;
      run('{8'h0B, `FC_WRITE_WORDS, 8'h08, 8'h00, 8'h00, 8'h02, 8'h04, 8'h7F, 8'hFF, 8'h3F, 8'hFF}, 1'b1, 6, 1);
      check_val("word image", exp_words, words);
      $display("test multi done");
   endtask
   task test_bad;
      run('{8'h0B, `FC_WRITE_COIL, 8'h00, 8'h03, `COIL_OFF_VALUE, 8'h00}, 1'b0, 0, 0);
      run('{8'h0B, `FC_WRITE_COIL, 8'h00, 8'h03, 8'h12, 8'h00}, 1'b1, 0, 0);
      run('{8'h0B, `FC_WRITE_COIL, 8'h00, 8'h40, `COIL_ON_VALUE, 8'h00}, 1'b1, 0, 0);
      run('{8'h0B, `FC_WRITE_WORD, 8'h00, 8'h03, 8'h12, 8'h34}, 1'b1, 0, 0);
      check_val("coil image", exp_coils, coils);
      check_val("word image", exp_words, words);
      $display("test bad done");
   endtask
   task summarize;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #500000;
      errors++;
      summarize;
   end
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      test_single;
      test_multi;
      test_bad;
      summarize;
   end
endmodule // output_write_handler_tb
